/* File: logic/mrr_consts.svh */
// Constants for the measurement result readout: register offsets,
// field positions, channel codes and host register map.
// Assumes inclusion by bare name from the device, host, monitor and bench files.
`ifndef MRR_CONSTS_SVH
`define MRR_CONSTS_SVH

// Device register offsets
`define MRR_OFS_CONV_CTRL     8'h85
`define MRR_OFS_SCAN_CTRL     8'h87
`define MRR_OFS_THERM1_LOW    8'hA2
`define MRR_OFS_THERM1_HIGH   8'hA3
`define MRR_OFS_THERM2_LOW    8'hA4
`define MRR_OFS_THERM2_HIGH   8'hA5
`define MRR_OFS_PACK_LOW      8'hA6
`define MRR_OFS_PACK_HIGH     8'hA7
`define MRR_OFS_REG_LOW       8'hA8
`define MRR_OFS_REG_HIGH      8'hA9
`define MRR_OFS_RAW_LOW       8'hAA
`define MRR_OFS_RAW_HIGH      8'hAB

// Field positions
`define MRR_BIT_TAKEOVER      2
`define MRR_BIT_START         6
`define MRR_CHAN_MSB          3

// Channel codes that aim the converter at a thermistor input
`define MRR_CHAN_THERM1       4'h8
`define MRR_CHAN_THERM2       4'h9

// Result widths and raw decode
`define MRR_RES_W             12
`define MRR_RAW_W             14
`define MRR_RAW_NEG_FROM      14'h1FFF
`define MRR_RAW_SPAN          15'h4000

// Reset values
`define MRR_RST_BYTE          8'h00
`define MRR_RST_RES           12'h000
`define MRR_RST_RAW           14'h0000
`define MRR_RST_CHAN          4'h0

// Host Avalon register byte addresses
`define MRR_AV_CMD            4'h0
`define MRR_AV_STATUS         4'h4
`define MRR_AV_RESULT         4'h8

// Host command word fields
`define MRR_CMD_OP_LSB        16
`define MRR_CMD_OP_MSB        18
`define MRR_CMD_DATA_LSB      8
`define MRR_CMD_DATA_MSB      15
`define MRR_CMD_ADDR_MSB      7

`endif

/* File: logic/mrr_pkg.sv */
// Types used by the host end and the bench of the measurement result readout.
// Assumes mrr_consts.svh supplies all numeric constants.
package mrr_pkg;

	typedef enum logic [2:0] {
		MRR_OP_READ,
		MRR_OP_WRITE,
		MRR_OP_PAIR,
		MRR_OP_CONVERT
	} mrr_op_t;

	typedef enum logic [3:0] {
		MRR_S_IDLE,
		MRR_S_SINGLE,
		MRR_S_TAKE,
		MRR_S_SELECT,
		MRR_S_START,
		MRR_S_POLL,
		MRR_S_LOW,
		MRR_S_HIGH
	} mrr_state_t;

endpackage : mrr_pkg

/* File: logic/mrr_if.sv */
// Register link between the readout device and its host controller.
// Assumes both ends share clk; no tristate, byte-wide handshake.
`timescale 1ns/1ps
interface mrr_if;
	logic       req;
	logic       we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;

	modport device (
		input  req,
		input  we,
		input  addr,
		input  wdata,
		output ack,
		output rdata
	);

	modport host (
		output req,
		output we,
		output addr,
		output wdata,
		input  ack,
		input  rdata
	);
endinterface : mrr_if

/* File: logic/mrr_device.sv */
// Device end: result registers, scan takeover control and input mux.
// Assumes converter codes arrive already scaled and on the same clock.
//
// Notes on behaviour
// - Thermistor result low byte, then high nibble
// - Thermistor pairs refreshed from latest scan
// - Host ignores thermistor high reserved nibble
// - Pack voltage split over A6 and A7
// - Pack code is pin voltage over 32
// - Regulator voltage split over A8 and A9
// - Regulator code is pin voltage halved
// - Raw result is 14-bit two's complement
// - Raw low byte AA, six bits AB
// - Host ignores raw high top bits
// - Raw result meaningless during automatic scanning
// - Takeover, select channel, start, then convert
// - Host decodes raw codes above 8190 negative
// - One differential cell pair muxed at once
// - Bias on when host selects thermistor
`timescale 1ns/1ps
`include "mrr_consts.svh"
module mrr_device (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Register link
	mrr_if.device            link,
	// Automatic scan results
	input  wire logic        scan_done,
	input  wire logic [11:0] scan_therm1,
	input  wire logic [11:0] scan_therm2,
	input  wire logic [11:0] scan_pack,
	input  wire logic [11:0] scan_regulator,
	// Automatic scan mux and bias requests
	input  wire logic [3:0]  auto_channel,
	input  wire logic        auto_bias,
	// Converter
	output logic             conv_begin,
	input  wire logic        conv_done,
	input  wire logic [13:0] conv_code,
	// Analogue front end control
	output logic [3:0]       cell_sense_input,
	output logic             thermistor_bias_output
);

	logic [11:0] thermistor_one_result;
	logic [11:0] thermistor_two_result;
	logic [11:0] pack_voltage_result;
	logic [11:0] regulator_voltage_result;
	logic [13:0] raw_conversion_result;
	logic        host_scan_takeover;
	logic [3:0]  channel_select;
	logic        conversion_start_bit;
	logic        conv_pending;
	logic        wr_conv;
	logic        start_fire;
	logic [7:0]  next_rdata;

	assign wr_conv    = link.req & link.we & (link.addr == `MRR_OFS_CONV_CTRL);
	assign start_fire = conversion_start_bit & host_scan_takeover & ~conv_pending;

	// ------------------------------------------------------------
	// Scan results
	// ------------------------------------------------------------
	// Whole words held so both bytes change on one edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			thermistor_one_result    <= `MRR_RST_RES;
			thermistor_two_result    <= `MRR_RST_RES;
			pack_voltage_result      <= `MRR_RST_RES;
			regulator_voltage_result <= `MRR_RST_RES;
		end else if (ce && scan_done) begin
			thermistor_one_result    <= scan_therm1;
			thermistor_two_result    <= scan_therm2;
			pack_voltage_result      <= scan_pack;
			regulator_voltage_result <= scan_regulator;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			raw_conversion_result <= `MRR_RST_RAW;
		end else if (ce && conv_done) begin
			raw_conversion_result <= conv_code;
		end
	end

	// ------------------------------------------------------------
	// Scan control
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			host_scan_takeover <= 1'b0;
		end else if (ce && link.req && link.we && link.addr == `MRR_OFS_SCAN_CTRL) begin
			host_scan_takeover <= link.wdata[`MRR_BIT_TAKEOVER];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			channel_select <= `MRR_RST_CHAN;
		end else if (ce && wr_conv) begin
			channel_select <= link.wdata[`MRR_CHAN_MSB:0];
		end
	end

	// A host write of the start bit wins over the completion clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			conversion_start_bit <= 1'b0;
		end else if (ce) begin
			if (wr_conv) begin
				conversion_start_bit <= link.wdata[`MRR_BIT_START];
			end else if (conv_pending && conv_done) begin
				conversion_start_bit <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			conv_pending <= 1'b0;
		end else if (ce) begin
			if (start_fire) begin
				conv_pending <= 1'b1;
			end else if (conv_done) begin
				conv_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			conv_begin <= 1'b0;
		end else if (ce) begin
			conv_begin <= start_fire;
		end else begin
			conv_begin <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Front end selection
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cell_sense_input <= `MRR_RST_CHAN;
		end else if (ce) begin
			cell_sense_input <= host_scan_takeover ? channel_select : auto_channel;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			thermistor_bias_output <= 1'b0;
		end else if (ce) begin
			if (host_scan_takeover) begin
				thermistor_bias_output <= (channel_select == `MRR_CHAN_THERM1) ||
				                          (channel_select == `MRR_CHAN_THERM2);
			end else begin
				thermistor_bias_output <= auto_bias;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = `MRR_RST_BYTE;
		if (link.addr == `MRR_OFS_THERM1_LOW) begin
			next_rdata = thermistor_one_result[7:0];
		end else if (link.addr == `MRR_OFS_THERM1_HIGH) begin
			next_rdata = {4'h0, thermistor_one_result[11:8]};
		end else if (link.addr == `MRR_OFS_THERM2_LOW) begin
			next_rdata = thermistor_two_result[7:0];
		end else if (link.addr == `MRR_OFS_THERM2_HIGH) begin
			next_rdata = {4'h0, thermistor_two_result[11:8]};
		end else if (link.addr == `MRR_OFS_PACK_LOW) begin
			next_rdata = pack_voltage_result[7:0];
		end else if (link.addr == `MRR_OFS_PACK_HIGH) begin
			next_rdata = {4'h0, pack_voltage_result[11:8]};
		end else if (link.addr == `MRR_OFS_REG_LOW) begin
			next_rdata = regulator_voltage_result[7:0];
		end else if (link.addr == `MRR_OFS_REG_HIGH) begin
			next_rdata = {4'h0, regulator_voltage_result[11:8]};
		end else if (link.addr == `MRR_OFS_RAW_LOW) begin
			next_rdata = raw_conversion_result[7:0];
		end else if (link.addr == `MRR_OFS_RAW_HIGH) begin
			next_rdata = {2'h0, raw_conversion_result[13:8]};
		end else if (link.addr == `MRR_OFS_CONV_CTRL) begin
			next_rdata = {1'b0, conversion_start_bit, 2'h0, channel_select};
		end else if (link.addr == `MRR_OFS_SCAN_CTRL) begin
			next_rdata = {5'h00, host_scan_takeover, 2'h0};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			link.rdata <= `MRR_RST_BYTE;
		end else if (ce && link.req && !link.we) begin
			link.rdata <= next_rdata;
		end
	end

	// One-cycle answer to every request; no answer while ack stands
	always_ff @(posedge clk) begin
		if (!rstn) begin
			link.ack <= 1'b0;
		end else if (ce) begin
			link.ack <= link.req & ~link.ack;
		end
	end

endmodule : mrr_device

/* File: logic/mrr_host.sv */
// Host end: Avalon-MM command registers driving the register link.
// Assumes the device answers each request with a one-cycle ack.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "mrr_consts.svh"
module mrr_host (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Register link
	mrr_if.host              link
);

	mrr_pkg::mrr_state_t state;
	mrr_pkg::mrr_op_t    op;
	logic [7:0]          cmd_addr;
	logic [7:0]          cmd_data;
	logic [7:0]          last_byte;
	logic [7:0]          low_byte;
	logic [15:0]         result;
	logic                raw_invalid;
	logic                takeover_seen;
	logic                rd_done;
	logic                busy;
	logic                cmd_take;
	logic [31:0]         next_readdata;

	assign busy     = (state != mrr_pkg::MRR_S_IDLE);
	assign cmd_take = ce & avs_write & ~busy & (avs_address == `MRR_AV_CMD);

	// Reads take one wait cycle, command writes stall while busy
	assign avs_waitrequest = (avs_read & ~rd_done) | (avs_write & busy);

	function automatic logic [15:0] decode_pair(input logic [7:0] addr, input logic [7:0] lo,
	                                            input logic [7:0] hi);
		logic [14:0] raw;
		raw = {1'b0, hi[5:0], lo};
		if (addr == `MRR_OFS_RAW_LOW) begin
			if (raw[13:0] >= `MRR_RAW_NEG_FROM) begin
				raw = raw - `MRR_RAW_SPAN;
			end
			decode_pair = {raw[14], raw};
		end else begin
			decode_pair = {4'h0, hi[3:0], lo};
		end
	endfunction : decode_pair

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= mrr_pkg::MRR_S_IDLE;
		end else if (ce) begin
			case (state)
			mrr_pkg::MRR_S_IDLE: begin
				if (cmd_take) begin
					case (mrr_pkg::mrr_op_t'(avs_writedata[`MRR_CMD_OP_MSB:`MRR_CMD_OP_LSB]))
					mrr_pkg::MRR_OP_PAIR:    state <= mrr_pkg::MRR_S_LOW;
					mrr_pkg::MRR_OP_CONVERT: state <= mrr_pkg::MRR_S_TAKE;
					default:                 state <= mrr_pkg::MRR_S_SINGLE;
					endcase
				end
			end
			mrr_pkg::MRR_S_SINGLE: if (link.ack) state <= mrr_pkg::MRR_S_IDLE;
			mrr_pkg::MRR_S_TAKE:   if (link.ack) state <= mrr_pkg::MRR_S_SELECT;
			mrr_pkg::MRR_S_SELECT: if (link.ack) state <= mrr_pkg::MRR_S_START;
			mrr_pkg::MRR_S_START:  if (link.ack) state <= mrr_pkg::MRR_S_POLL;
			mrr_pkg::MRR_S_POLL: begin
				if (link.ack && !link.rdata[`MRR_BIT_START]) begin
					state <= mrr_pkg::MRR_S_LOW;
				end
			end
			mrr_pkg::MRR_S_LOW:    if (link.ack) state <= mrr_pkg::MRR_S_HIGH;
			mrr_pkg::MRR_S_HIGH:   if (link.ack) state <= mrr_pkg::MRR_S_IDLE;
			default:               state <= mrr_pkg::MRR_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			op       <= mrr_pkg::MRR_OP_READ;
			cmd_addr <= `MRR_RST_BYTE;
			cmd_data <= `MRR_RST_BYTE;
		end else if (cmd_take) begin
			op       <= mrr_pkg::mrr_op_t'(avs_writedata[`MRR_CMD_OP_MSB:`MRR_CMD_OP_LSB]);
			cmd_addr <= (avs_writedata[`MRR_CMD_OP_MSB:`MRR_CMD_OP_LSB] == 3'(mrr_pkg::MRR_OP_CONVERT)) ?
			            `MRR_OFS_RAW_LOW : avs_writedata[`MRR_CMD_ADDR_MSB:0];
			cmd_data <= avs_writedata[`MRR_CMD_DATA_MSB:`MRR_CMD_DATA_LSB];
		end
	end

	// ------------------------------------------------------------
	// Link drive
	// ------------------------------------------------------------
	always_comb begin
		link.req   = busy & ~link.ack;
		link.we    = 1'b0;
		link.addr  = cmd_addr;
		link.wdata = cmd_data;
		case (state)
		mrr_pkg::MRR_S_SINGLE: link.we = (op == mrr_pkg::MRR_OP_WRITE);
		mrr_pkg::MRR_S_TAKE: begin
			link.we    = 1'b1;
			link.addr  = `MRR_OFS_SCAN_CTRL;
			link.wdata = 8'(1 << `MRR_BIT_TAKEOVER);
		end
		mrr_pkg::MRR_S_SELECT: begin
			link.we    = 1'b1;
			link.addr  = `MRR_OFS_CONV_CTRL;
			link.wdata = {4'h0, cmd_data[`MRR_CHAN_MSB:0]};
		end
		mrr_pkg::MRR_S_START: begin
			link.we    = 1'b1;
			link.addr  = `MRR_OFS_CONV_CTRL;
			link.wdata = {4'h0, cmd_data[`MRR_CHAN_MSB:0]} | 8'(1 << `MRR_BIT_START);
		end
		mrr_pkg::MRR_S_POLL: link.addr = `MRR_OFS_CONV_CTRL;
		mrr_pkg::MRR_S_HIGH: link.addr = cmd_addr + 8'h01;
		default: ;
		endcase
	end

	// ------------------------------------------------------------
	// Results
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			takeover_seen <= 1'b0;
		end else if (ce && link.ack && link.we && link.addr == `MRR_OFS_SCAN_CTRL) begin
			takeover_seen <= link.wdata[`MRR_BIT_TAKEOVER];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			last_byte <= `MRR_RST_BYTE;
			low_byte  <= `MRR_RST_BYTE;
		end else if (ce && link.ack) begin
			if (state == mrr_pkg::MRR_S_SINGLE && op == mrr_pkg::MRR_OP_READ) begin
				last_byte <= link.rdata;
			end
			if (state == mrr_pkg::MRR_S_LOW) begin
				low_byte <= link.rdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			result      <= 16'h0000;
			raw_invalid <= 1'b0;
		end else if (ce && link.ack && state == mrr_pkg::MRR_S_HIGH) begin
			result      <= decode_pair(cmd_addr, low_byte, link.rdata);
			raw_invalid <= (cmd_addr == `MRR_OFS_RAW_LOW) & ~takeover_seen;
		end
	end

	// ------------------------------------------------------------
	// Avalon read
	// ------------------------------------------------------------
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (avs_address == `MRR_AV_STATUS) begin
			next_readdata = {21'h00_0000, raw_invalid, takeover_seen, busy, last_byte};
		end else if (avs_address == `MRR_AV_RESULT) begin
			next_readdata = {16'h0000, result};
		end else if (avs_address == `MRR_AV_CMD) begin
			next_readdata = {13'h0000, 3'(op), cmd_data, cmd_addr};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_done      <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else if (ce) begin
			rd_done <= avs_read & ~rd_done;
			if (avs_read && !rd_done) begin
				avs_readdata <= next_readdata;
			end
		end
	end

endmodule : mrr_host

/* File: tb/mrr_monitor.sv */
// Checker for the register link joining the device and host ends.
// Assumes one clock, synchronous active-low reset, link signals as plain inputs.
`timescale 1ns/1ps
`include "mrr_consts.svh"
module mrr_monitor (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Register link
	input  wire logic       req,
	input  wire logic       we,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       ack,
	input  wire logic [7:0] rdata,
	// Front end outputs
	input  wire logic       conv_begin,
	input  wire logic [3:0] cell_sense_input,
	input  wire logic       thermistor_bias_output
);
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Shadow of takeover and channel writes
	// ----------------------------------------
	logic       tk_m;
	logic [3:0] chan_m;
	logic       hit_m;
	assign hit_m = (chan_m == `MRR_CHAN_THERM1) || (chan_m == `MRR_CHAN_THERM2);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tk_m <= 1'b0;
		end else if (req && !ack && we && addr == `MRR_OFS_SCAN_CTRL) begin
			tk_m <= wdata[`MRR_BIT_TAKEOVER];
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			chan_m <= `MRR_RST_CHAN;
		end else if (req && !ack && we && addr == `MRR_OFS_CONV_CTRL) begin
			chan_m <= wdata[`MRR_CHAN_MSB:0];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_req_taken;
		req && !ack;
	endsequence
	sequence s_answer;
		ack && !req;
	endsequence
	sequence s_read_of(logic [7:0] a);
		req && !ack && !we && addr == a;
	endsequence

	a_ack_next_cycle: assert property (s_req_taken |=> s_answer)
		else $error("link request not answered on the next cycle");
	a_ack_one_wide: assert property (ack |=> !ack)
		else $error("link ack wider than one cycle");
	a_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
		else $error("link ack without a request");
	a_request_held: assert property (s_req_taken |=> $stable(addr) && $stable(we) && $stable(wdata))
		else $error("link request changed before its ack");
	a_res_high_clean: assert property ((s_read_of(`MRR_OFS_THERM1_HIGH) or s_read_of(`MRR_OFS_THERM2_HIGH)
		or s_read_of(`MRR_OFS_PACK_HIGH) or s_read_of(`MRR_OFS_REG_HIGH)) |=> rdata[7:4] == 4'h0)
		else $error("result high byte carries reserved bits");
	a_raw_high_clean: assert property (s_read_of(`MRR_OFS_RAW_HIGH) |=> rdata[7:6] == 2'b00)
		else $error("raw high byte carries reserved bits");
	a_begin_one_wide: assert property (conv_begin |=> !conv_begin)
		else $error("conversion start wider than one cycle");
	a_begin_needs_take: assert property (conv_begin |-> tk_m)
		else $error("conversion started without host takeover");
	a_bias_on_therm: assert property ((tk_m && hit_m) [*2] |-> thermistor_bias_output)
		else $error("bias off while a thermistor input is selected");
	a_bias_off_other: assert property ((tk_m && !hit_m) [*2] |-> !thermistor_bias_output)
		else $error("bias on while no thermistor input is selected");
	a_mux_follows_sel: assert property ((tk_m && $stable(chan_m)) [*2] |-> cell_sense_input == chan_m)
		else $error("input mux differs from selected channel");
endmodule : mrr_monitor

/* File: tb/testbench.sv */
// Self-checking bench: host and device ends joined by the register link.
// Assumes the host Avalon map and op codes of mrr_consts.svh and mrr_pkg.
`timescale 1ns/1ps
`include "mrr_consts.svh"
module testbench;
	logic        clk;
	logic        rstn;
	logic        ce;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        scan_done;
	logic [11:0] scan_therm1;
	logic [11:0] scan_therm2;
	logic [11:0] scan_pack;
	logic [11:0] scan_regulator;
	logic [3:0]  auto_channel;
	logic        auto_bias;
	logic        conv_begin;
	logic        conv_done;
	logic [13:0] conv_code;
	logic [13:0] code_q;
	logic [3:0]  cell_sense_input;
	logic        thermistor_bias_output;
	int          err_count;
	int          n_checks;

	mrr_if link ();
	mrr_device u_mrr_device (.clk(clk), .rstn(rstn), .ce(ce), .link(link.device), .scan_done(scan_done),
		.scan_therm1(scan_therm1), .scan_therm2(scan_therm2), .scan_pack(scan_pack),
		.scan_regulator(scan_regulator), .auto_channel(auto_channel), .auto_bias(auto_bias),
		.conv_begin(conv_begin), .conv_done(conv_done), .conv_code(conv_code),
		.cell_sense_input(cell_sense_input), .thermistor_bias_output(thermistor_bias_output));
	mrr_host u_mrr_host (.clk(clk), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link.host));
	mrr_monitor u_mrr_monitor (.clk(clk), .rstn(rstn), .req(link.req), .we(link.we), .addr(link.addr),
		.wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .conv_begin(conv_begin),
		.cell_sense_input(cell_sense_input), .thermistor_bias_output(thermistor_bias_output));

	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic guard(inout int n);
		n++;
		if (n > 300) begin
			err_count++;
			give_verdict();
		end
	endtask : guard

	task automatic av_xfer(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= rd;
		avs_write     <= !rd;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			guard(n);
			@(posedge clk);
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : av_xfer

	task automatic cmd(input mrr_pkg::mrr_op_t op, input logic [7:0] dat, input logic [7:0] a,
		output logic [31:0] st);
		int n;
		n = 0;
		av_xfer(1'b0, `MRR_AV_CMD, {13'h0000, op, dat, a}, st);
		st = 32'h0000_0100;
		while (st[8] !== 1'b0) begin
			guard(n);
			av_xfer(1'b1, `MRR_AV_STATUS, 32'h0000_0000, st);
		end
	endtask : cmd

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_scan_results;
		logic [11:0] v [4];
		logic [31:0] q;
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 4; k++) begin
				v[k] = 12'(12'h5A3 * (p + 1) + k * 12'h2F1);
			end
			@(posedge clk);
			scan_therm1    <= v[0];
			scan_therm2    <= v[1];
			scan_pack      <= v[2];
			scan_regulator <= v[3];
			scan_done      <= 1'b1;
			@(posedge clk);
			scan_done <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				cmd(mrr_pkg::MRR_OP_PAIR, 8'h00, 8'(`MRR_OFS_THERM1_LOW + 2 * k), q);
				av_xfer(1'b1, `MRR_AV_RESULT, 32'h0000_0000, q);
				check(q, 32'(v[k]));
				cmd(mrr_pkg::MRR_OP_READ, 8'h00, 8'(`MRR_OFS_THERM1_HIGH + 2 * k), q);
				check(32'(q[7:0]), 32'(v[k][11:8]));
			end
		end
		cmd(mrr_pkg::MRR_OP_READ, 8'h00, 8'h10, q);
		check(32'(q[7:0]), 32'h0000_0000);
		av_xfer(1'b1, 4'hC, 32'h0000_0000, q);
		check(q, 32'h0000_0000);
	endtask : t_scan_results

	task automatic t_convert;
		logic [13:0] codes [4];
		logic [3:0]  chans [4];
		logic [31:0] q;
		codes = '{14'h0005, 14'h1FFE, 14'h1FFF, 14'h3FFF};
		chans = '{4'h3, 4'h8, 4'h9, 4'h0};
		for (int i = 0; i < 4; i++) begin
			code_q = codes[i];
			cmd(mrr_pkg::MRR_OP_CONVERT, {4'h0, chans[i]}, 8'h00, q);
			check(32'(q[9]), 32'h0000_0001);
			av_xfer(1'b1, `MRR_AV_RESULT, 32'h0000_0000, q);
			check(q, {16'h0000, codes[i] >= 14'h1FFF ? {2'b11, codes[i]} : {2'b00, codes[i]}});
			check(32'(cell_sense_input), 32'(chans[i]));
			check(32'(thermistor_bias_output), 32'(chans[i] == 4'h8 || chans[i] == 4'h9));
			cmd(mrr_pkg::MRR_OP_READ, 8'h00, `MRR_OFS_RAW_HIGH, q);
			check(32'(q[7:0]), 32'(codes[i][13:8]));
		end
	endtask : t_convert

	task automatic t_auto_mode;
		logic [31:0] q;
		cmd(mrr_pkg::MRR_OP_WRITE, 8'h00, `MRR_OFS_SCAN_CTRL, q);
		for (int b = 0; b < 2; b++) begin
			@(posedge clk);
			auto_channel <= 4'(6 + b);
			auto_bias    <= b[0];
			repeat (3) @(posedge clk);
			check(32'(cell_sense_input), 32'(6 + b));
			check(32'(thermistor_bias_output), 32'(b));
		end
		// Enable low must freeze the input mux
		@(posedge clk);
		ce           <= 1'b0;
		auto_channel <= 4'h5;
		repeat (3) @(posedge clk);
		check(32'(cell_sense_input), 32'h0000_0007);
		ce <= 1'b1;
		cmd(mrr_pkg::MRR_OP_PAIR, 8'h00, `MRR_OFS_RAW_LOW, q);
		check(32'(q[10]), 32'h0000_0001);
		av_xfer(1'b1, `MRR_AV_CMD, 32'h0000_0000, q);
		check(q, {13'h0000, mrr_pkg::MRR_OP_PAIR, 8'h00, `MRR_OFS_RAW_LOW});
	endtask : t_auto_mode

	// ----------------------------------------
	// Clock, converter answer, watchdog, main
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		forever begin
			@(negedge clk);
			if (conv_begin === 1'b1) begin
				repeat (3) @(posedge clk);
				conv_code <= code_q;
				conv_done <= 1'b1;
				@(posedge clk);
				conv_done <= 1'b0;
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		scan_done = 1'b0;
		scan_therm1 = 12'h000;
		scan_therm2 = 12'h000;
		scan_pack = 12'h000;
		scan_regulator = 12'h000;
		auto_channel = 4'h0;
		auto_bias = 1'b0;
		conv_done = 1'b0;
		conv_code = 14'h0000;
		code_q = 14'h0000;
		err_count = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_scan_results();
		t_convert();
		t_auto_mode();
		give_verdict();
	end
endmodule : testbench
